/* File: verilog/i2c_slave_address_detect.sv */
// Slave address recognition, start/stop tracking, acknowledge and clock stretching.
// Assumes open-drain pins resolved outside; config and strobes come from ref_clk_in logic.
//
// What this block does
// - Every incoming serial bit is sampled on the rising edge of the bus clock.
// - Start or repeated start sets start flag, clears stop; stop does the reverse.
// - Reset or module disable clears both start and stop flags.
// - After start, the ten-bit select chooses one or two address bytes to match.
// - Direction bit zero means slave receives; one means slave transmits.
// - Each set mask bit makes that address bit a don't-care in both modes.
// - Masking acts only while accept-all is off.
// - Seven-bit mode compares shifter bits 7..1 with own address 6..0 at eighth fall.
// - Valid seven-bit write: acknowledge, clear data and direction flags, interrupt at ninth fall.
// - Valid read: acknowledge, set direction, interrupt, hold clock low until software releases.
// - Clock release is cleared after a read address whatever stretch enable says.
// - First ten-bit byte needs prefix 11110 and unmasked upper two address bits matching.
// - Valid first ten-bit byte: acknowledge, clear data and direction flags, interrupt.
// - Second ten-bit byte matches low eight bits; sets ten-bit matched flag, interrupts.
// - After a repeated start following a full ten-bit match only the first byte is matched.
// - The first ten-bit byte always carries a write direction.
// - General call is recognised only while general call enable is set.
// - General call: acknowledge, flag it, clear flags, capture byte, interrupt.
// - General call is still detected while in ten-bit addressing mode.
// - Received data is interrupted; it is acknowledged and copied to the receive buffer only while the buffer is empty.
// - The slave never starts a transaction; it is active only from a start until a stop, a failed address match or a read byte the master does not acknowledge.
// - A failed address match ignores the bus until the next stop.
// - Accept-all takes every address regardless of mode, general call or own address.
`timescale 1ns/1ps
module i2c_slave_address_detect (
  input logic ref_clk_in,
  input logic rst_in,
  input logic serial_clock_pin_in,
  input logic serial_data_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_out,
  input i2c_slave_pkg::slave_cfg_s cfg_in,
  input logic [7:0] tx_buffer_in,
  input logic clock_release_set_in,
  input logic irq_clear_in,
  input logic rx_buffer_read_in,
  output i2c_slave_pkg::slave_status_s status_out,
  output logic clock_release_out,
  output logic [7:0] rx_buffer_out
);
  i2c_slave_pkg::engine_s q;
  i2c_slave_pkg::engine_s n;
  i2c_slave_pkg::link_s lk;
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic bit_rise;
  logic active;
  logic [9:0] care;
  logic match7;
  logic match_hi;
  logic match_lo;
  logic gc_hit;

  // The bus clock may stand still between frames, so this domain only records the
  // sampled bit and flips a toggle; everything else happens on the system clock.
  // An asynchronous reset is used here because no link edge is guaranteed during reset.
  always_ff @(posedge serial_clock_pin_in or posedge rst_in) begin
    if (rst_in) begin
      lk <= '0;
    end else begin
      lk.bit_val <= serial_data_pin_in;
      lk.bit_tog <= ~lk.bit_tog;
    end
  end

  // Start and stop are data edges while the clock stays high in both sampled cycles.
  assign start_det = q.sync.scl_s2 & q.sync.scl_d & q.sync.sda_d & ~q.sync.sda_s2;
  assign stop_det = q.sync.scl_s2 & q.sync.scl_d & ~q.sync.sda_d & q.sync.sda_s2;
  assign scl_fall = q.sync.scl_d & ~q.sync.scl_s2;
  assign bit_rise = q.sync.tog_s2 ^ q.sync.tog_d;
  assign active = (q.st != i2c_slave_pkg::ST_IDLE) && (q.st != i2c_slave_pkg::ST_IGNORE);

  assign care = ~cfg_in.addr_mask;
  assign match7 = ((q.rx_shift_reg[7:1] ^ cfg_in.own_address[6:0]) & care[6:0]) == '0;
  assign match_hi = (q.rx_shift_reg[7:3] == i2c_slave_pkg::TEN_BIT_PREFIX) &&
                    (((q.rx_shift_reg[2:1] ^ cfg_in.own_address[9:8]) & care[9:8]) == '0) &&
                    (q.rx_shift_reg[0] == i2c_slave_pkg::DIR_WRITE);
  assign match_lo = ((q.rx_shift_reg ^ cfg_in.own_address[7:0]) & care[7:0]) == '0;
  assign gc_hit = cfg_in.general_call_enable &&
                  (q.rx_shift_reg == i2c_slave_pkg::GENERAL_CALL_BYTE);

  always_comb begin
    i2c_slave_pkg::pin_sync_s keep;
    keep = '0;
    n = q;
    n.sync.sda_s1 = serial_data_pin_in;
    n.sync.sda_s2 = q.sync.sda_s1;
    n.sync.sda_d = q.sync.sda_s2;
    n.sync.scl_s1 = serial_clock_pin_in;
    n.sync.scl_s2 = q.sync.scl_s1;
    n.sync.scl_d = q.sync.scl_s2;
    n.sync.tog_s1 = lk.bit_tog;
    n.sync.tog_s2 = q.sync.tog_s1;
    n.sync.tog_d = q.sync.tog_s2;
    // Software clears come first so that a hardware set in the same cycle wins.
    if (irq_clear_in) begin
      n.stat.slave_irq_flag = 1'b0;
    end
    if (rx_buffer_read_in) begin
      n.stat.rx_buffer_full = 1'b0;
    end
    if (clock_release_set_in) begin
      n.hold_clk = 1'b0;
      if (q.st == i2c_slave_pkg::ST_TX) begin
        n.tx_shift = tx_buffer_in;
        n.tx_drive = 1'b1;
      end
    end
    if (start_det) begin
      n.stat.start_seen_flag = 1'b1;
      n.stat.stop_seen_flag = 1'b0;
      if (q.st != i2c_slave_pkg::ST_IGNORE) begin
        n.st = i2c_slave_pkg::ST_ADDR_HI;
        n.bit_cnt = i2c_slave_pkg::BIT_COUNT_START;
        n.ack_drive = 1'b0;
        n.tx_drive = 1'b0;
        n.irq_pend = 1'b0;
        n.stretch_pend = 1'b0;
      end
    end else if (stop_det) begin
      n.stat.stop_seen_flag = 1'b1;
      n.stat.start_seen_flag = 1'b0;
      n.stat.ten_bit_matched_flag = 1'b0;
      n.st = i2c_slave_pkg::ST_IDLE;
      n.ack_drive = 1'b0;
      n.tx_drive = 1'b0;
    end else if (bit_rise && active) begin
      n.rx_shift_reg = {q.rx_shift_reg[6:0], lk.bit_val};
      n.bit_cnt = q.bit_cnt + i2c_slave_pkg::BIT_COUNT_STEP;
    end else if (scl_fall && active) begin
      if (q.bit_cnt == i2c_slave_pkg::ADDR_EVAL_COUNT) begin
        unique case (q.st)
          i2c_slave_pkg::ST_ADDR_HI: begin
            n.st = i2c_slave_pkg::ST_IGNORE;
            // General call is tried before the own address so that an own address of
            // zero cannot hide the general call status.
            if (cfg_in.accept_all_enable) begin
              n.st = q.rx_shift_reg[0] ? i2c_slave_pkg::ST_TX : i2c_slave_pkg::ST_RX;
              n.stat.read_not_write_flag = q.rx_shift_reg[0];
            end else if (gc_hit) begin
              n.st = i2c_slave_pkg::ST_RX;
              n.stat.general_call_seen = 1'b1;
              n.stat.read_not_write_flag = 1'b0;
              n.rx_buffer = q.rx_shift_reg;
              n.stat.rx_buffer_full = 1'b1;
            end else if (!cfg_in.ten_bit_addr_select && match7) begin
              n.st = q.rx_shift_reg[0] ? i2c_slave_pkg::ST_TX : i2c_slave_pkg::ST_RX;
              n.stat.read_not_write_flag = q.rx_shift_reg[0];
            end else if (cfg_in.ten_bit_addr_select && match_hi) begin
              // A repeated start after a full ten-bit match needs only this byte.
              n.st = q.stat.ten_bit_matched_flag ?
                     i2c_slave_pkg::ST_RX : i2c_slave_pkg::ST_ADDR_LO;
              n.stat.read_not_write_flag = 1'b0;
            end
            if (n.st != i2c_slave_pkg::ST_IGNORE) begin
              n.ack_drive = 1'b1;
              n.stat.data_not_address_flag = 1'b0;
              n.irq_pend = 1'b1;
            end
            if (n.st == i2c_slave_pkg::ST_TX) begin
              n.stretch_pend = 1'b1;
            end
          end
          i2c_slave_pkg::ST_ADDR_LO: begin
            if (match_lo) begin
              n.st = i2c_slave_pkg::ST_RX;
              n.stat.ten_bit_matched_flag = 1'b1;
              n.ack_drive = 1'b1;
              n.irq_pend = 1'b1;
            end else begin
              n.st = i2c_slave_pkg::ST_IGNORE;
            end
          end
          i2c_slave_pkg::ST_RX: begin
            n.stat.data_not_address_flag = 1'b1;
            n.irq_pend = 1'b1;
            n.stretch_pend = cfg_in.stretch_enable;
            // A byte arriving over a full buffer is dropped and not acknowledged.
            if (!q.stat.rx_buffer_full) begin
              n.rx_buffer = q.rx_shift_reg;
              n.stat.rx_buffer_full = 1'b1;
              n.ack_drive = 1'b1;
            end
          end
          default: begin
            n.tx_drive = 1'b0;
          end
        endcase
      end else if (q.bit_cnt == i2c_slave_pkg::ACK_COUNT) begin
        n.bit_cnt = i2c_slave_pkg::BIT_COUNT_START;
        n.ack_drive = 1'b0;
        n.irq_pend = 1'b0;
        n.stretch_pend = 1'b0;
        if (q.irq_pend) begin
          n.stat.slave_irq_flag = 1'b1;
        end
        if (q.stretch_pend) begin
          n.hold_clk = 1'b1;
        end
        if (q.st == i2c_slave_pkg::ST_TX) begin
          if (q.rx_shift_reg[0] == i2c_slave_pkg::NACK_LEVEL) begin
            n.st = i2c_slave_pkg::ST_IGNORE;
          end else begin
            n.hold_clk = 1'b1;
            n.stat.slave_irq_flag = 1'b1;
          end
        end
      end else if ((q.st == i2c_slave_pkg::ST_TX) && q.tx_drive &&
                   (q.bit_cnt != i2c_slave_pkg::BIT_COUNT_START)) begin
        n.tx_shift = {q.tx_shift[6:0], 1'b0};
      end
    end
    if (!cfg_in.module_enable) begin
      keep = n.sync;
      n = '0;
      n.sync = keep;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Both pins are open drain: the block only ever pulls low.
  assign serial_data_pin_out = i2c_slave_pkg::PIN_LOW;
  assign serial_clock_pin_out = i2c_slave_pkg::PIN_LOW;
  assign serial_data_pin_oe_out = q.ack_drive | (q.tx_drive & ~q.tx_shift[7]);
  assign serial_clock_pin_oe_out = q.hold_clk;
  assign clock_release_out = ~q.hold_clk;
  assign status_out = q.stat;
  assign rx_buffer_out = q.rx_buffer;

  sequence s_eighth_fall;
    scl_fall && active && !start_det && !stop_det &&
    (q.bit_cnt == i2c_slave_pkg::ADDR_EVAL_COUNT);
  endsequence

  sequence s_ninth_fall;
    scl_fall && active && !start_det && !stop_det &&
    (q.bit_cnt == i2c_slave_pkg::ACK_COUNT);
  endsequence

  a_link_sample: assert property (
    @(posedge serial_clock_pin_in) disable iff (rst_in)
    1'b1 |=> (lk.bit_val == $past(serial_data_pin_in)) && (lk.bit_tog != $past(lk.bit_tog)))
    else $error("Link bit not sampled on clock rise.");

  a_start_flags: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    start_det && cfg_in.module_enable |=> q.stat.start_seen_flag && !q.stat.stop_seen_flag)
    else $error("Start did not set start flag and clear stop flag.");

  a_stop_flags: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    stop_det && cfg_in.module_enable |=>
    q.stat.stop_seen_flag && !q.stat.start_seen_flag && (q.st == i2c_slave_pkg::ST_IDLE))
    else $error("Stop did not set stop flag and return to idle.");

  a_disable_clears: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !cfg_in.module_enable |=> !q.stat.start_seen_flag && !q.stat.stop_seen_flag &&
    !serial_clock_pin_oe_out && !serial_data_pin_oe_out)
    else $error("Disable left flags or pin drive active.");

  a_addr7_ack: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_ADDR_HI) && cfg_in.module_enable &&
    !cfg_in.accept_all_enable && !cfg_in.ten_bit_addr_select && match7 |=>
    q.ack_drive && !q.stat.data_not_address_flag &&
    (q.stat.read_not_write_flag == $past(q.rx_shift_reg[0])))
    else $error("Seven-bit match not acknowledged with correct flags.");

  a_ten_hi_miss: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_ADDR_HI) && cfg_in.module_enable &&
    cfg_in.ten_bit_addr_select && !cfg_in.accept_all_enable && !gc_hit && !match_hi |=>
    (q.st == i2c_slave_pkg::ST_IGNORE) && !q.ack_drive)
    else $error("Bad ten-bit first byte was not rejected.");

  a_ten_lo_match: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_ADDR_LO) && cfg_in.module_enable && match_lo
    |=> q.stat.ten_bit_matched_flag && q.ack_drive && (q.st == i2c_slave_pkg::ST_RX))
    else $error("Ten-bit low byte match not taken.");

  a_gc_capture: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_ADDR_HI) && cfg_in.module_enable &&
    !cfg_in.accept_all_enable && gc_hit |=> q.stat.general_call_seen &&
    q.stat.rx_buffer_full && (q.rx_buffer == $past(q.rx_shift_reg)))
    else $error("General call byte not captured.");

  a_irq_ninth: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_ninth_fall ##0 q.irq_pend && cfg_in.module_enable |=> q.stat.slave_irq_flag && !q.ack_drive)
    else $error("Slave interrupt not raised at ninth fall.");

  a_read_hold: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_ninth_fall ##0 (q.st == i2c_slave_pkg::ST_TX) && q.stretch_pend && cfg_in.module_enable
    |=> !clock_release_out && serial_clock_pin_oe_out)
    else $error("Read address did not hold the clock low.");

  a_irq_sticky: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    q.stat.slave_irq_flag && !irq_clear_in && cfg_in.module_enable |=> q.stat.slave_irq_flag)
    else $error("Slave interrupt flag dropped without a clear.");

  a_ignore_hold: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (q.st == i2c_slave_pkg::ST_IGNORE) && !stop_det && cfg_in.module_enable |=>
    (q.st == i2c_slave_pkg::ST_IGNORE))
    else $error("Ignore state left before a stop.");

  a_no_initiate: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (q.st == i2c_slave_pkg::ST_IDLE) |-> !serial_data_pin_oe_out)
    else $error("Data pin driven while idle.");

  // Checks below cover the less travelled branches: repeated ten-bit start, overrun,
  // accept-all and software release of a stretched clock.
  a_ten_repeat: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_ADDR_HI) && cfg_in.module_enable &&
    cfg_in.ten_bit_addr_select && !cfg_in.accept_all_enable && !gc_hit && match_hi &&
    q.stat.ten_bit_matched_flag |=> (q.st == i2c_slave_pkg::ST_RX) && q.ack_drive)
    else $error("Repeated ten-bit start did not skip the low byte.");

  a_ten_dir_write: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_ADDR_HI) && cfg_in.module_enable &&
    cfg_in.ten_bit_addr_select && !cfg_in.accept_all_enable &&
    q.rx_shift_reg[0] |=> (q.st == i2c_slave_pkg::ST_IGNORE))
    else $error("Ten-bit first byte with read direction was taken.");

  a_gc_off: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_ADDR_HI) && cfg_in.module_enable &&
    !cfg_in.general_call_enable |=>
    (q.stat.general_call_seen == $past(q.stat.general_call_seen)))
    else $error("General call flagged while disabled.");

  a_rx_capture: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_RX) && cfg_in.module_enable &&
    !q.stat.rx_buffer_full |=> q.ack_drive && q.stat.rx_buffer_full &&
    q.stat.data_not_address_flag && (q.rx_buffer == $past(q.rx_shift_reg)))
    else $error("Received byte not captured and acknowledged.");

  a_rx_overrun: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_RX) && cfg_in.module_enable &&
    q.stat.rx_buffer_full |=> !q.ack_drive && (q.rx_buffer == $past(q.rx_buffer)))
    else $error("Byte over a full buffer was stored or acknowledged.");

  a_accept_all: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    s_eighth_fall ##0 (q.st == i2c_slave_pkg::ST_ADDR_HI) && cfg_in.module_enable &&
    cfg_in.accept_all_enable |=> q.ack_drive && (q.st != i2c_slave_pkg::ST_IGNORE))
    else $error("Accept-all did not take the address.");

  a_release_clock: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    clock_release_set_in && cfg_in.module_enable &&
    !(scl_fall && active && (q.bit_cnt == i2c_slave_pkg::ACK_COUNT)) |=>
    clock_release_out && !serial_clock_pin_oe_out)
    else $error("Software release did not free the clock.");
endmodule // i2c_slave_address_detect

/* File: common/i2c_slave_pkg.sv */
// Constants, modes and carrier structs for the two-wire slave address detector.
// Assumes one importer that qualifies every name with the package scope.
package i2c_slave_pkg;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [7:0] GENERAL_CALL_BYTE = 8'h00;
  localparam logic [3:0] ADDR_EVAL_COUNT = 4'h8;
  localparam logic [3:0] ACK_COUNT = 4'h9;
  localparam logic [3:0] BIT_COUNT_START = 4'h0;
  localparam logic [3:0] BIT_COUNT_STEP = 4'h1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic NACK_LEVEL = 1'b1;
  localparam logic PIN_LOW = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_RX,
    ST_TX,
    ST_IGNORE
  } slave_state_e;

  typedef struct packed {
    logic module_enable;
    logic ten_bit_addr_select;
    logic accept_all_enable;
    logic general_call_enable;
    logic stretch_enable;
    logic [9:0] own_address;
    logic [9:0] addr_mask;
  } slave_cfg_s;

  typedef struct packed {
    logic start_seen_flag;
    logic stop_seen_flag;
    logic data_not_address_flag;
    logic read_not_write_flag;
    logic ten_bit_matched_flag;
    logic general_call_seen;
    logic rx_buffer_full;
    logic slave_irq_flag;
  } slave_status_s;

  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic tog_s1;
    logic tog_s2;
    logic tog_d;
  } pin_sync_s;

  typedef struct packed {
    pin_sync_s sync;
    slave_state_e st;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift_reg;
    logic [7:0] rx_buffer;
    logic [7:0] tx_shift;
    slave_status_s stat;
    logic hold_clk;
    logic ack_drive;
    logic tx_drive;
    logic irq_pend;
    logic stretch_pend;
  } engine_s;

  typedef struct packed {
    logic bit_val;
    logic bit_tog;
  } link_s;
endpackage

/* File: verif/i2c_bus_master_model.sv */
// Behavioural bus master that frames starts, stops and bytes on the two-wire bus.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
module i2c_bus_master_model (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rel_out,
  output logic sda_rel_out,
  output logic stall_out
);
  initial begin
    scl_rel_out = 1'b1;
    sda_rel_out = 1'b1;
    stall_out = 1'b0;
  end

  // The slave may stretch the clock, so a release waits for the wire, with a bound.
  task automatic rel_clk();
    int n;
    n = 0;
    scl_rel_out = 1'b1;
    while (scl_in !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    if (scl_in !== 1'b1) begin
      stall_out = 1'b1;
    end
  endtask

  // Data moves only while the clock is low; the 27 ns lead keeps edges off the system clock.
  task automatic clk_bit(input logic b, output logic s);
    #27;
    sda_rel_out = b;
    #53;
    rel_clk();
    #71;
    s = sda_in;
    #9;
    scl_rel_out = 1'b0;
  endtask

  // Also serves as a repeated start when called with the clock held low.
  task automatic start_cond();
    #27;
    sda_rel_out = 1'b1;
    #53;
    rel_clk();
    #80;
    sda_rel_out = 1'b0;
    #80;
    scl_rel_out = 1'b0;
  endtask

  task automatic stop_cond();
    #27;
    sda_rel_out = 1'b0;
    #53;
    rel_clk();
    #80;
    sda_rel_out = 1'b1;
    #160;
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = (s === 1'b0);
  endtask

  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(nack, s);
  endtask
endmodule // i2c_bus_master_model

/* File: verif/i2c_slave_address_detect_tb_top.sv */
// Self-checking bench: a bus master model addresses the slave address detector.
// Assumes the package and design are compiled first; both wires have pull-ups.
`timescale 1ns/1ps
module i2c_slave_address_detect_tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  i2c_slave_pkg::slave_cfg_s cfg = '0;
  logic [7:0] tx_buf = 8'h00;
  logic rel_set = 1'b0;
  logic irq_clr = 1'b0;
  logic rx_rd = 1'b0;
  logic scl_rel, sda_rel, stall, scl_oe, sda_oe, clk_rel, scl_w, sda_w, scl_o, sda_o;
  logic [7:0] rx_buf;
  i2c_slave_pkg::slave_status_s st;
  int error_cnt = 0;
  int checks_done = 0;

  // An enabled pin pulls the wire low when the block puts out a low; it never drives the wire high.
  assign scl_w = scl_rel & ~(scl_oe & ~scl_o);
  assign sda_w = sda_rel & ~(sda_oe & ~sda_o);
  always #10 ref_clk_in = ~ref_clk_in;

  i2c_slave_address_detect DUT (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .serial_clock_pin_in(scl_w),
    .serial_data_pin_in(sda_w),
    .serial_clock_pin_out(scl_o),
    .serial_clock_pin_oe_out(scl_oe),
    .serial_data_pin_out(sda_o),
    .serial_data_pin_oe_out(sda_oe),
    .cfg_in(cfg),
    .tx_buffer_in(tx_buf),
    .clock_release_set_in(rel_set),
    .irq_clear_in(irq_clr),
    .rx_buffer_read_in(rx_rd),
    .status_out(st),
    .clock_release_out(clk_rel),
    .rx_buffer_out(rx_buf)
  );

  i2c_bus_master_model master (
    .scl_in(scl_w),
    .sda_in(sda_w),
    .scl_rel_out(scl_rel),
    .sda_rel_out(sda_rel),
    .stall_out(stall)
  );

  task automatic finish_test();
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h", $time, what, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask

  // One-cycle software strobes: clock release, interrupt clear, receive buffer read.
  task automatic sw(input logic r, input logic c, input logic x);
    rel_set = r;
    irq_clr = c;
    rx_rd = x;
    cyc(1);
    {rel_set, irq_clr, rx_rd} = 3'h0;
  endtask

  // Disabling first clears everything left from the previous scenario.
  task automatic setup(input logic ten, input logic all, input logic gc,
                       input logic [9:0] own, input logic [9:0] mask);
    cfg.module_enable = 1'b0;
    cyc(3);
    cfg = {1'b1, ten, all, gc, 1'b0, own, mask};
    cyc(5);
  endtask

  task automatic frame(input logic [7:0] b, input logic exp_ack);
    logic ack;
    master.start_cond();
    master.write_byte(b, ack);
    chk1(ack, exp_ack, "address acknowledge");
    cyc(10);
  endtask

  task automatic t_write7();
    logic ack;
    setup(1'b0, 1'b0, 1'b0, 10'h012, 10'h020);
    frame({7'h32, 1'b0}, 1'b1);
    chk8(st[7:4], 8'h08, "start, stop, data, direction");
    chk1(st.slave_irq_flag, 1'b1, "address irq");
    sw(1'b0, 1'b1, 1'b0);
    chk1(st.slave_irq_flag, 1'b0, "irq clear");
    cfg.stretch_enable = 1'b1;
    master.write_byte(8'ha5, ack);
    cyc(10);
    chk1(ack, 1'b1, "data acknowledge");
    chk8(rx_buf, 8'ha5, "receive buffer");
    chk8({st.data_not_address_flag, st.rx_buffer_full}, 8'h03, "data flags");
    chk8({clk_rel, scl_oe}, 8'h01, "receive stretch");
    cfg.stretch_enable = 1'b0;
    sw(1'b1, 1'b0, 1'b0);
    chk8({clk_rel, scl_oe}, 8'h02, "stretch released");
    master.write_byte(8'h5a, ack);
    cyc(10);
    chk1(ack, 1'b0, "full buffer refused");
    chk8(rx_buf, 8'ha5, "full buffer kept");
    master.stop_cond();
    cyc(10);
    chk8(st[7:6], 8'h01, "stop flags");
    chk1(st.slave_irq_flag, 1'b1, "irq stays set");
    sw(1'b0, 1'b0, 1'b1);
    chk1(st.rx_buffer_full, 1'b0, "buffer read");
    cfg.module_enable = 1'b0;
    cyc(3);
    chk8(st[7:6], 8'h00, "disable clears");
  endtask

  task automatic t_nomatch();
    logic ack;
    setup(1'b0, 1'b0, 1'b0, 10'h012, 10'h000);
    frame({7'h32, 1'b0}, 1'b0);
    master.start_cond();
    master.write_byte({7'h12, 1'b0}, ack);
    chk1(ack, 1'b0, "ignored after mismatch");
    chk1(st.slave_irq_flag, 1'b0, "no irq");
    master.stop_cond();
  endtask

  task automatic t_read();
    logic [7:0] d;
    setup(1'b0, 1'b0, 1'b0, 10'h012, 10'h000);
    frame({7'h12, 1'b1}, 1'b1);
    chk1(st.read_not_write_flag, 1'b1, "read direction");
    chk1(clk_rel, 1'b0, "release cleared");
    chk1(scl_oe, 1'b1, "clock held");
    chk1(st.slave_irq_flag, 1'b1, "read irq");
    tx_buf = 8'h3c;
    sw(1'b1, 1'b0, 1'b0);
    chk1(clk_rel, 1'b1, "release set");
    master.read_byte(1'b1, d);
    chk8(d, 8'h3c, "read data");
    master.stop_cond();
  endtask

  task automatic t_ten();
    logic ack;
    logic [7:0] hi;
    hi = {i2c_slave_pkg::TEN_BIT_PREFIX, 2'b10, i2c_slave_pkg::DIR_WRITE};
    setup(1'b1, 1'b0, 1'b1, 10'h2a5, 10'h000);
    frame(hi, 1'b1);
    chk8(st[5:3], 8'h00, "first byte flags");
    chk1(st.slave_irq_flag, 1'b1, "first byte irq");
    sw(1'b0, 1'b1, 1'b0);
    master.write_byte(8'ha5, ack);
    cyc(10);
    chk1(ack, 1'b1, "low byte acknowledge");
    chk1(st.ten_bit_matched_flag, 1'b1, "ten-bit matched");
    chk1(st.slave_irq_flag, 1'b1, "low byte irq");
    frame(hi, 1'b1);
    master.stop_cond();
    frame(i2c_slave_pkg::GENERAL_CALL_BYTE, 1'b1);
    chk1(st.general_call_seen, 1'b1, "general call flag");
    chk1(st.rx_buffer_full, 1'b1, "general call buffer");
    chk8(rx_buf, 8'h00, "general call byte");
    chk8(st[5:4], 8'h00, "general call flags");
    master.stop_cond();
  endtask

  task automatic t_special();
    setup(1'b0, 1'b0, 1'b0, 10'h012, 10'h000);
    frame(8'h00, 1'b0);
    master.stop_cond();
    setup(1'b0, 1'b1, 1'b0, 10'h012, 10'h000);
    frame(8'hbc, 1'b1);
    chk1(st.read_not_write_flag, 1'b0, "accept-all direction");
    master.stop_cond();
  endtask

  initial begin
    cyc(10);
    rst_in = 1'b0;
    cyc(5);
    chk8(st, 8'h00, "status after reset");
    chk8({clk_rel, scl_oe, sda_oe, scl_o, sda_o}, 8'h10, "pins after reset");
    t_write7();
    t_nomatch();
    t_read();
    t_ten();
    t_special();
    chk1(stall, 1'b0, "clock never freed");
    finish_test();
  end

  // About thirteen bus bytes need well under 100 us; the limit leaves wide margin.
  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end
endmodule // i2c_slave_address_detect_tb_top
